/* File: core/srh_top.sv */
// Status register hierarchy: status byte, standard event group and operation group
module srh_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Controller commands and answers
    input srh_pkg::srh_cmd_t cmd,
    output srh_pkg::srh_resp_t resp,
    // Operation condition pins, asynchronous
    input wire logic [srh_pkg::REG_W-1:0] oper_cond_pin,
    // Standard event pulses from same-clock logic, bits 0 to 6
    input wire logic [srh_pkg::BYTE_W-1:0] std_ev_pulse,
    // Summary levels from same-clock logic
    input wire logic err_queue_nonempty,
    input wire logic output_message_available,
    input wire logic ques_summary,
    // Service request line and status byte view
    output logic srq,
    output logic [srh_pkg::BYTE_W-1:0] status_byte
);
    import srh_pkg::*;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic [REG_W-1:0] sync1_r, sync2_r;

    // Two stages before the group reads the pins
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= oper_cond_pin;
            sync2_r <= sync1_r;
        end
    end

    // ****************************************
    // Operation group
    // ****************************************
    srh_grp_ctl_t oper_ctl;
    srh_grp_view_t oper_view;
    logic oper_sum;

    srh_group u_oper (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cond_in(sync2_r & OPER_USED_MASK),
        .ctl(oper_ctl),
        .view(oper_view),
        .summary(oper_sum)
    );

    // ****************************************
    // Command decode
    // ****************************************
    logic is_cls;
    logic do_poll;

    // Lower groups through status subsystem ops, top registers through common ops
    always_comb begin
        is_cls = cmd.valid && cmd.op == SRH_OP_CLS;
        do_poll = cmd.valid && cmd.op == SRH_OP_SPOLL;
        oper_ctl.wr_enab = cmd.valid && cmd.op == SRH_OP_OPER_ENAB_W;
        oper_ctl.wr_ptr = cmd.valid && cmd.op == SRH_OP_OPER_PTR_W;
        oper_ctl.wr_ntr = cmd.valid && cmd.op == SRH_OP_OPER_NTR_W;
        oper_ctl.preset = cmd.valid && cmd.op == SRH_OP_STAT_PRES;
        oper_ctl.clear_ev = is_cls || (cmd.valid && cmd.op == SRH_OP_OPER_EVEN_R);
        oper_ctl.data = cmd.data;
    end

    // ****************************************
    // Standard event group and service request
    // ****************************************
    logic [BYTE_W-1:0] std_ev_r, std_ev_nxt;
    logic [BYTE_W-1:0] ese_r, ese_nxt;
    logic [BYTE_W-1:0] sre_r, sre_nxt;
    logic pending_r, pending_nxt;
    logic std_sum;
    logic [BYTE_W-1:0] stb_core;
    logic [BYTE_W-1:0] stb_now;
    logic srq_start;

    always_comb begin
        std_sum = |(std_ev_r & ese_r);
        // Status byte without the request bit; bits 0 and 1 stay zero
        stb_core = '0;
        stb_core[STB_QUEUE_BIT] = err_queue_nonempty;
        stb_core[STB_QUES_BIT] = ques_summary;
        stb_core[STB_MSG_BIT] = output_message_available;
        stb_core[STB_STD_BIT] = std_sum;
        stb_core[STB_OPER_BIT] = oper_sum;
        stb_now = stb_core;
        stb_now[STB_REQ_BIT] = pending_r;
        // Request bit is never its own trigger, so it is masked out of the compare
        srq_start = |(stb_core & sre_r & SRE_VALID_MASK) && !pending_r;
        // Poll clears; a still-enabled bit may start the next request a cycle later
        pending_nxt = do_poll ? 1'b0 : (pending_r || srq_start);
        // Pulses beat a read clear in the same cycle; power-on only comes from reset
        std_ev_nxt = (is_cls || (cmd.valid && cmd.op == SRH_OP_ESR_R)) ? '0 : std_ev_r;
        std_ev_nxt = std_ev_nxt | (std_ev_pulse & ~(8'h01 << STD_POWER_ON_BIT));
        ese_nxt = ese_r;
        sre_nxt = sre_r;
        if (cmd.valid && cmd.op == SRH_OP_ESE_W) begin
            ese_nxt = cmd.data[BYTE_W-1:0];
        end
        if (cmd.valid && cmd.op == SRH_OP_SRE_W) begin
            sre_nxt = cmd.data[BYTE_W-1:0] & SRE_VALID_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            std_ev_r <= STD_EV_RESET;
            ese_r <= ESE_RESET;
            sre_r <= SRE_RESET;
            pending_r <= 1'b0;
        end else begin
            std_ev_r <= std_ev_nxt;
            ese_r <= ese_nxt;
            sre_r <= sre_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ****************************************
    // Answers
    // ****************************************
    srh_resp_t resp_r, resp_nxt;
    logic [BYTE_W-1:0] stb_r, stb_nxt;

    // Every query answers one cycle later with the plain weighted value
    always_comb begin
        resp_nxt.valid = 1'b0;
        resp_nxt.data = '0;
        stb_nxt = stb_now;
        if (cmd.valid) begin
            resp_nxt.valid = 1'b1;
            case (cmd.op)
                SRH_OP_ESE_R: resp_nxt.data = {8'h00, ese_r};
                SRH_OP_ESR_R: resp_nxt.data = {8'h00, std_ev_r};
                SRH_OP_SRE_R: resp_nxt.data = {8'h00, sre_r};
                SRH_OP_STB_R: resp_nxt.data = {8'h00, stb_now};
                SRH_OP_SPOLL: resp_nxt.data = {8'h00, stb_now};
                SRH_OP_OPER_COND_R: resp_nxt.data = oper_view.cond;
                SRH_OP_OPER_EVEN_R: resp_nxt.data = oper_view.event_bits;
                SRH_OP_OPER_ENAB_R: resp_nxt.data = oper_view.enab;
                SRH_OP_OPER_PTR_R: resp_nxt.data = oper_view.ptr;
                SRH_OP_OPER_NTR_R: resp_nxt.data = oper_view.ntr;
                default: resp_nxt.valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            resp_r <= '0;
            stb_r <= '0;
        end else begin
            resp_r <= resp_nxt;
            stb_r <= stb_nxt;
        end
    end

    assign resp = resp_r;
    assign status_byte = stb_r;
    assign srq = pending_r;

    // ****************************************
    // Checks
    // ****************************************
    srq_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        srq_start && !do_poll |=> srq ##1 status_byte[STB_REQ_BIT])
        else $error("service request not raised for an enabled bit");
    srq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !pending_r && !(|(stb_core & sre_r & SRE_VALID_MASK)) |=> !srq)
        else $error("service request raised with no enabled cause");
    poll_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        do_poll |=> !pending_r ##1 !status_byte[STB_REQ_BIT])
        else $error("serial poll left the request bit set");
    esr_read_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.valid && cmd.op == SRH_OP_ESR_R && std_ev_pulse == 8'h00 |=> std_ev_r == 8'h00)
        else $error("standard event register not cleared by its read");
    query_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.valid && cmd.op == SRH_OP_OPER_COND_R |=> resp.valid && resp.data == $past(oper_view.cond))
        else $error("condition query answer wrong or late");
    stb_unused_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        status_byte[1:0] == 2'b00)
        else $error("unused status byte bits set");
    // Write, latch and answer checks
    std_pulse_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        std_ev_pulse != 8'h00 |=> (std_ev_r | ~$past(std_ev_pulse) | (8'h01 << STD_POWER_ON_BIT)) == 8'hFF)
        else $error("standard event pulse did not latch");
    std_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !is_cls && !(cmd.valid && cmd.op == SRH_OP_ESR_R) |=> (std_ev_r & $past(std_ev_r)) == $past(std_ev_r))
        else $error("standard event bit dropped without a clear");
    cls_clears_std_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        is_cls && std_ev_pulse == 8'h00 |=> std_ev_r == 8'h00)
        else $error("clear-status left a standard event bit set");
    power_on_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !std_ev_r[STD_POWER_ON_BIT] |=> !std_ev_r[STD_POWER_ON_BIT])
        else $error("power-on bit set outside reset");
    stb_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> status_byte == $past(stb_now))
        else $error("status byte output lags by more than one cycle");
    resp_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cmd.valid |=> !resp.valid)
        else $error("answer given with no command");
    ese_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.valid && cmd.op == SRH_OP_ESE_W |=> ese_r == $past(cmd.data[BYTE_W-1:0]))
        else $error("event enable write not applied as a whole mask");
    sre_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.valid && cmd.op == SRH_OP_SRE_W |=> sre_r == ($past(cmd.data[BYTE_W-1:0]) & SRE_VALID_MASK))
        else $error("request enable write not applied as a whole mask");
    esr_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.valid && cmd.op == SRH_OP_ESR_R |=> resp.valid && resp.data == {8'h00, $past(std_ev_r)})
        else $error("standard event query answer wrong or late");
    poll_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        do_poll |=> resp.valid && resp.data == {8'h00, $past(stb_now)})
        else $error("serial poll answer wrong or late");
    req_enable_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !sre_r[STB_REQ_BIT])
        else $error("request bit enabled as its own trigger");

endmodule : srh_top

/* File: core/srh_pkg.sv */
// Constants, command codes and carrier types for the status register hierarchy
// Contract
// - Registers form a hierarchy; each group feeds one summary bit to the status byte.
// - Bit n carries weight two to the n; values are plain sums of set weights.
// - Bit 15 of every sixteen-bit status register always reads zero.
// - One written value is applied as the complete bit mask of the register.
// - A register query returns the sum of weights of all bits set.
// - Condition bits follow their live condition continuously, never latched.
// - Per-bit positive and negative filters choose which condition edges are recorded.
// - A filtered edge sets the event bit, which stays set until read or cleared.
// - Reading an event register clears it; clear-status clears every event register.
// - After preset, filters record rising edges only; falling edges need explicit enabling.
// - Status byte holds queue, questionable, message, standard event, request and operation bits.
// - Standard event register holds its eight documented bits, power-on in bit 7.
// - Operation condition uses bits 0, 1, 3, 5 and 11; all others read zero.
// - Top summary registers use common commands; group registers use status subsystem commands.
// - Service request starts when an enabled status byte bit is set and none pends.
// - Serial poll clears the request summary bit and leaves other status byte bits alone.
package srh_pkg;

    // ****************************************
    // Widths and masks
    // ****************************************
    localparam int REG_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [REG_W-1:0] REG_VALID_MASK = 16'h7FFF;
    localparam logic [REG_W-1:0] OPER_USED_MASK = 16'h082B;
    localparam logic [BYTE_W-1:0] SRE_VALID_MASK = 8'hBF;

    // ****************************************
    // Reset and preset values
    // ****************************************
    localparam logic [REG_W-1:0] PTR_PRESET = 16'h7FFF;
    localparam logic [REG_W-1:0] NTR_PRESET = 16'h0000;
    localparam logic [REG_W-1:0] ENAB_PRESET = 16'h0000;
    localparam logic [BYTE_W-1:0] STD_EV_RESET = 8'h80;
    localparam logic [BYTE_W-1:0] SRE_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] ESE_RESET = 8'h00;

    // ****************************************
    // Status byte and standard event field positions
    // ****************************************
    localparam int STB_QUEUE_BIT = 2;
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MSG_BIT = 4;
    localparam int STB_STD_BIT = 5;
    localparam int STB_REQ_BIT = 6;
    localparam int STB_OPER_BIT = 7;
    localparam int STD_POWER_ON_BIT = 7;

    // ****************************************
    // Controller commands
    // ****************************************
    typedef enum logic [4:0] {
        SRH_OP_NONE,
        SRH_OP_CLS,
        SRH_OP_ESE_W,
        SRH_OP_ESE_R,
        SRH_OP_ESR_R,
        SRH_OP_SRE_W,
        SRH_OP_SRE_R,
        SRH_OP_STB_R,
        SRH_OP_SPOLL,
        SRH_OP_OPER_COND_R,
        SRH_OP_OPER_EVEN_R,
        SRH_OP_OPER_ENAB_W,
        SRH_OP_OPER_ENAB_R,
        SRH_OP_OPER_PTR_W,
        SRH_OP_OPER_PTR_R,
        SRH_OP_OPER_NTR_W,
        SRH_OP_OPER_NTR_R,
        SRH_OP_STAT_PRES
    } srh_op_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        srh_op_t op;
        logic [REG_W-1:0] data;
    } srh_cmd_t;

    typedef struct packed {
        logic valid;
        logic [REG_W-1:0] data;
    } srh_resp_t;

    typedef struct packed {
        logic wr_enab;
        logic wr_ptr;
        logic wr_ntr;
        logic preset;
        logic clear_ev;
        logic [REG_W-1:0] data;
    } srh_grp_ctl_t;

    typedef struct packed {
        logic [REG_W-1:0] cond;
        logic [REG_W-1:0] ptr;
        logic [REG_W-1:0] ntr;
        logic [REG_W-1:0] event_bits;
        logic [REG_W-1:0] enab;
    } srh_grp_view_t;

    // Drops the always-zero top bit
    function automatic logic [REG_W-1:0] srh_clip(input logic [REG_W-1:0] v);
        return v & REG_VALID_MASK;
    endfunction : srh_clip

endpackage : srh_pkg

/* File: core/srh_group.sv */
// One sixteen-bit status group: condition, transition filters, event and enable
module srh_group (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Live conditions, already in this clock domain
    input wire logic [srh_pkg::REG_W-1:0] cond_in,
    // Register writes and clears
    input srh_pkg::srh_grp_ctl_t ctl,
    // Register contents and summary
    output srh_pkg::srh_grp_view_t view,
    output logic summary
);
    import srh_pkg::*;

    logic [REG_W-1:0] cond_r, cond_nxt;
    logic [REG_W-1:0] ptr_r, ptr_nxt;
    logic [REG_W-1:0] ntr_r, ntr_nxt;
    logic [REG_W-1:0] ev_r, ev_nxt;
    logic [REG_W-1:0] enab_r, enab_nxt;
    logic [REG_W-1:0] edge_hit;

    // ****************************************
    // Next values
    // ****************************************
    always_comb begin
        cond_nxt = srh_clip(cond_in);
        // Edge seen on the registered copy so it lines up with what a query shows
        edge_hit = (cond_nxt & ~cond_r & ptr_r) | (~cond_nxt & cond_r & ntr_r);
        // A new edge beats a clear arriving in the same cycle
        ev_nxt = srh_clip((ctl.clear_ev ? '0 : ev_r) | edge_hit);
        ptr_nxt = ptr_r;
        ntr_nxt = ntr_r;
        enab_nxt = enab_r;
        if (ctl.preset) begin
            ptr_nxt = PTR_PRESET;
            ntr_nxt = NTR_PRESET;
            enab_nxt = ENAB_PRESET;
        end
        if (ctl.wr_ptr) begin
            ptr_nxt = srh_clip(ctl.data);
        end
        if (ctl.wr_ntr) begin
            ntr_nxt = srh_clip(ctl.data);
        end
        if (ctl.wr_enab) begin
            enab_nxt = srh_clip(ctl.data);
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cond_r <= '0;
            ptr_r <= PTR_PRESET;
            ntr_r <= NTR_PRESET;
            ev_r <= '0;
            enab_r <= ENAB_PRESET;
        end else begin
            cond_r <= cond_nxt;
            ptr_r <= ptr_nxt;
            ntr_r <= ntr_nxt;
            ev_r <= ev_nxt;
            enab_r <= enab_nxt;
        end
    end

    // Summary follows event and enable without a register stage
    assign summary = |(ev_r & enab_r);
    assign view = '{cond: cond_r, ptr: ptr_r, ntr: ntr_r, event_bits: ev_r, enab: enab_r};

    // ****************************************
    // Checks
    // ****************************************
    top_bit_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !ev_r[REG_W-1] && !ptr_r[REG_W-1] && !ntr_r[REG_W-1] && !enab_r[REG_W-1] && !cond_r[REG_W-1])
        else $error("bit 15 of a group register is set");
    rise_sets_event_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (|(cond_nxt & ~cond_r & ptr_r)) |=> |(ev_r & $past(cond_nxt & ~cond_r & ptr_r)))
        else $error("enabled rising edge did not set its event bit");
    event_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !ctl.clear_ev |=> ((ev_r & $past(ev_r)) == $past(ev_r)))
        else $error("event bit dropped without a clear");
    cond_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> cond_r == srh_clip($past(cond_in)))
        else $error("condition register lags or latches its input");
    preset_filters_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ctl.preset && !ctl.wr_ptr && !ctl.wr_ntr |=> ptr_r == PTR_PRESET && ntr_r == NTR_PRESET)
        else $error("preset did not restore rising-only filters");

endmodule : srh_group

/* File: test/srh_ctrl_model.sv */
// Remote controller model that issues command words and collects answers
module srh_ctrl_model (
    // Clock
    input wire logic ref_clk,
    // Command port
    output srh_pkg::srh_cmd_t cmd,
    input srh_pkg::srh_resp_t resp
);
    timeunit 1ns;
    timeprecision 100ps;
    import srh_pkg::*;

    // Idle port at time zero
    initial begin
        cmd = '{valid: 1'b0, op: SRH_OP_NONE, data: 16'h0000};
    end

    // ****************************************
    // Command issue
    // ****************************************
    // One whole word per command, held across its taking edge; the value is the full mask
    task automatic send(input srh_op_t op, input logic [REG_W-1:0] val);
        @(negedge ref_clk);
        cmd = '{valid: 1'b1, op: op, data: val};
        @(negedge ref_clk);
        // Released data is inverted so nothing leans on a stale word
        cmd = '{valid: 1'b0, op: SRH_OP_NONE, data: ~val};
    endtask : send

    // Query and wait a bounded number of cycles for the answer strobe
    task automatic query(input srh_op_t op, output logic [REG_W-1:0] val, output logic got);
        got = 1'b0;
        val = 'x;
        send(op, 16'h0000);
        for (int i = 0; i < 4 && !got; i++) begin
            if (resp.valid === 1'b1) begin
                got = 1'b1;
                val = resp.data;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask : query

endmodule : srh_ctrl_model

/* File: test/test_srh_top.sv */
// Self-checking testbench for the status register hierarchy
module test_srh_top;
    timeunit 1ns;
    timeprecision 100ps;
    import srh_pkg::*;

    logic ref_clk;
    logic rst_b;
    srh_cmd_t cmd;
    srh_resp_t resp;
    logic [REG_W-1:0] oper_cond_pin;
    logic [BYTE_W-1:0] std_ev_pulse;
    logic err_queue_nonempty;
    logic output_message_available;
    logic ques_summary;
    logic srq;
    logic [BYTE_W-1:0] status_byte;
    int mismatches = 0;
    int tests_run = 0;

    // ****************************************
    // Clock, design and controller
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    srh_top dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .resp(resp), .oper_cond_pin(oper_cond_pin),
        .std_ev_pulse(std_ev_pulse), .err_queue_nonempty(err_queue_nonempty),
        .output_message_available(output_message_available), .ques_summary(ques_summary),
        .srq(srq), .status_byte(status_byte)
    );

    srh_ctrl_model ctl_u (.ref_clk(ref_clk), .cmd(cmd), .resp(resp));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input srh_op_t op, input logic [REG_W-1:0] exp);
        logic [REG_W-1:0] v;
        logic g;
        ctl_u.query(op, v, g);
        if (g !== 1'b1) begin
            v = 'x;
        end
        check(v, exp);
    endtask : rd_chk

    // Covers the fixed condition pipeline plus event latch
    task automatic settle();
        repeat (6) @(negedge ref_clk);
    endtask : settle

    task automatic close_out();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Watchdog sized well above the two hundred or so cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        oper_cond_pin = 16'h0000;
        std_ev_pulse = 8'h00;
        err_queue_nonempty = 1'b0;
        output_message_available = 1'b0;
        ques_summary = 1'b0;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        check({8'h00, status_byte}, 16'h0000);
        // Reset contents
        rd_chk(SRH_OP_ESR_R, 16'h0080);
        rd_chk(SRH_OP_ESR_R, 16'h0000);
        rd_chk(SRH_OP_SRE_R, 16'h0000);
        rd_chk(SRH_OP_OPER_PTR_R, 16'h7FFF);
        rd_chk(SRH_OP_OPER_NTR_R, 16'h0000);
        // Masks applied whole, top bit dropped
        ctl_u.send(SRH_OP_OPER_ENAB_W, 16'hFFFF);
        rd_chk(SRH_OP_OPER_ENAB_R, 16'h7FFF);
        ctl_u.send(SRH_OP_ESE_W, 16'h0041);
        rd_chk(SRH_OP_ESE_R, 16'h0041);
        ctl_u.send(SRH_OP_SRE_W, 16'h00FF);
        rd_chk(SRH_OP_SRE_R, 16'h00BF);
        ctl_u.send(SRH_OP_OPER_PTR_W, 16'h8005);
        rd_chk(SRH_OP_OPER_PTR_R, 16'h0005);
        ctl_u.send(SRH_OP_OPER_NTR_W, 16'hFFFF);
        rd_chk(SRH_OP_OPER_NTR_R, 16'h7FFF);
        ctl_u.send(SRH_OP_STAT_PRES, 16'h0000);
        rd_chk(SRH_OP_OPER_PTR_R, 16'h7FFF);
        rd_chk(SRH_OP_OPER_NTR_R, 16'h0000);
        rd_chk(SRH_OP_OPER_ENAB_R, 16'h0000);
        ctl_u.send(SRH_OP_SRE_W, 16'h0000);
        // Live conditions and edge recording
        oper_cond_pin = 16'hFFFF;
        settle();
        rd_chk(SRH_OP_OPER_COND_R, 16'h082B);
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h082B);
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0000);
        oper_cond_pin = 16'h0000;
        settle();
        rd_chk(SRH_OP_OPER_COND_R, 16'h0000);
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0000);
        ctl_u.send(SRH_OP_OPER_NTR_W, 16'h0008);
        ctl_u.send(SRH_OP_OPER_PTR_W, 16'h0000);
        oper_cond_pin = 16'h0008;
        settle();
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0000);
        oper_cond_pin = 16'h0000;
        settle();
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0008);
        // Both filters on: either direction is recorded
        ctl_u.send(SRH_OP_OPER_PTR_W, 16'h0008);
        oper_cond_pin = 16'h0008;
        settle();
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0008);
        oper_cond_pin = 16'h0000;
        settle();
        rd_chk(SRH_OP_OPER_EVEN_R, 16'h0008);
        ctl_u.send(SRH_OP_STAT_PRES, 16'h0000);
        // Summary bits up the hierarchy
        ctl_u.send(SRH_OP_OPER_ENAB_W, 16'h0008);
        oper_cond_pin = 16'h0008;
        settle();
        check({8'h00, status_byte}, 16'h0080);
        rd_chk(SRH_OP_STB_R, 16'h0080);
        err_queue_nonempty = 1'b1;
        output_message_available = 1'b1;
        ques_summary = 1'b1;
        std_ev_pulse = 8'h01;
        @(negedge ref_clk);
        std_ev_pulse = 8'h00;
        repeat (2) @(negedge ref_clk);
        rd_chk(SRH_OP_STB_R, 16'h00BC);
        rd_chk(SRH_OP_ESR_R, 16'h0001);
        rd_chk(SRH_OP_STB_R, 16'h009C);
        err_queue_nonempty = 1'b0;
        output_message_available = 1'b0;
        ques_summary = 1'b0;
        // Service request, serial poll and clear-status
        ctl_u.send(SRH_OP_SRE_W, 16'h0080);
        repeat (3) @(negedge ref_clk);
        check({15'h0000, srq}, 16'h0001);
        check({8'h00, status_byte}, 16'h00C0);
        rd_chk(SRH_OP_SPOLL, 16'h00C0);
        // Power-on pulse ignored; a latched standard event must fall to clear-status
        std_ev_pulse = 8'h84;
        @(negedge ref_clk);
        std_ev_pulse = 8'h00;
        rd_chk(SRH_OP_ESR_R, 16'h0004);
        std_ev_pulse = 8'h04;
        @(negedge ref_clk);
        std_ev_pulse = 8'h00;
        ctl_u.send(SRH_OP_CLS, 16'h0000);
        repeat (4) @(negedge ref_clk);
        rd_chk(SRH_OP_SPOLL, 16'h0040);
        rd_chk(SRH_OP_ESR_R, 16'h0000);
        repeat (4) @(negedge ref_clk);
        check({15'h0000, srq}, 16'h0000);
        rd_chk(SRH_OP_STB_R, 16'h0000);
        // Mid-run reset brings back power-on and preset contents
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        rd_chk(SRH_OP_ESR_R, 16'h0080);
        rd_chk(SRH_OP_OPER_ENAB_R, 16'h0000);
        close_out();
    end

endmodule : test_srh_top
